// ===== src/tsc_regs.sv
// Tuner synthesiser control registers and status read-back.
// Assumes serial framing logic on mclk_i delivers byte writes and
// read requests; analog status and divider pins arrive asynchronously.
`timescale 1ns/1ns
module tsc_regs
   import tsc_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       wr_en_i,
   input  wire logic [7:0] wr_addr_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       rd_req_i,
   input  wire logic       loop1_locked_i,
   input  wire logic       loop2_locked_i,
   input  wire logic       loop1_tune_out_of_range_i,
   input  wire logic       loop2_tune_out_of_range_i,
   input  wire logic       loop1_fb_div_i,
   input  wire logic       loop1_ref_div_i,
   input  wire logic       loop2_fb_div_i,
   input  wire logic       loop2_ref_div_i,
   input  wire logic       ref_osc_i,
   output logic            wr_ack_o,
   output logic [7:0]      rd_data_o,
   output logic            rd_valid_o,
   output logic [7:0]      loop2_feedback_ratio_o,
   output logic [6:0]      loop2_reference_ratio_o,
   output logic [2:0]      tank_select_o,
   output logic [1:0]      loop1_pump_current_o,
   output logic [1:0]      loop2_pump_current_o,
   output logic [9:0]      loop1_pump_ua_o,
   output logic [9:0]      loop2_pump_ua_o,
   output logic [1:0]      filter_step_o,
   output logic            filter_step_down_o,
   output logic            filter_step_up_o,
   output logic            monitor_o,
   output logic            tank_go_lower_o,
   output logic            tank_go_higher_o,
   output logic            por_done_o
);

   // Pump current in microamps for a two-bit code
   function automatic logic [9:0] pump_ua(input logic [1:0] code);
      pump_ua = 10'(TSC_PUMP_STEP_UA * ({8'h00, code} + 10'h001));
   endfunction

   // Write strobe aimed at one register address
   function automatic logic addr_hit(input logic       en,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
      addr_hit = en && (addr == target);
   endfunction

   // Two-stage synchroniser for all asynchronous pins
   logic [8:0] pin_meta_r;
   logic [8:0] pin_sync_r;
   logic [8:0] pin_raw;

   assign pin_raw = {ref_osc_i, loop2_ref_div_i, loop2_fb_div_i,
                     loop1_ref_div_i, loop1_fb_div_i,
                     loop2_tune_out_of_range_i, loop1_tune_out_of_range_i,
                     loop2_locked_i, loop1_locked_i};

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pin_meta_r <= 9'h000;
         pin_sync_r <= 9'h000;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   wire loop1_locked_s = pin_sync_r[0];
   wire loop2_locked_s = pin_sync_r[1];
   wire ou1_s   = pin_sync_r[2];
   wire ou2_s   = pin_sync_r[3];
   wire fb1_s   = pin_sync_r[4];
   wire ref1_s  = pin_sync_r[5];
   wire fb2_s   = pin_sync_r[6];
   wire ref2_s  = pin_sync_r[7];
   wire osc_s   = pin_sync_r[8];

   // Address decode of the write map
   wire hit_fb   = addr_hit(wr_en_i, wr_addr_i, TSC_ADDR_FB_LOW);   // see R16
   wire hit_ref  = addr_hit(wr_en_i, wr_addr_i, TSC_ADDR_REF_DIV);  // see R16
   wire hit_osc  = addr_hit(wr_en_i, wr_addr_i, TSC_ADDR_OSC_SET);  // see R16
   wire hit_filt = addr_hit(wr_en_i, wr_addr_i, TSC_ADDR_FILT_MON); // see R14
   wire hit_any  = hit_fb | hit_ref | hit_osc | hit_filt;

   // Write registers, reserved bits never stored
   logic [7:0] fb_low_r;
   logic [7:0] fb_low_nxt;
   logic [6:0] ref_div_r;
   logic [6:0] ref_div_nxt;
   logic [2:0] tank_r;
   logic [2:0] tank_nxt;
   logic [1:0] cp1_r;
   logic [1:0] cp1_nxt;
   logic [1:0] cp2_r;
   logic [1:0] cp2_nxt;
   logic [1:0] step_r;
   logic [1:0] step_nxt;
   logic [3:0] mon_sel_r;
   logic [3:0] mon_sel_nxt;

   assign fb_low_nxt  = hit_fb ? wr_data_i : fb_low_r;                // see R1
   assign ref_div_nxt = hit_ref ? wr_data_i[TSC_REF_MSB:0]
                                : ref_div_r;                   // see R2 R18
   assign tank_nxt    = hit_osc ? wr_data_i[TSC_TANK_MSB:TSC_TANK_LSB]
                                : tank_r;                             // see R3
   assign cp1_nxt     = hit_osc ? wr_data_i[TSC_CP1_MSB:TSC_CP1_LSB]
                                : cp1_r;                              // see R4
   assign cp2_nxt     = hit_osc ? wr_data_i[TSC_CP2_MSB:TSC_CP2_LSB]
                                : cp2_r;                              // see R5
   assign step_nxt    = hit_filt ? wr_data_i[TSC_STEP_MSB:TSC_STEP_LSB]
                                 : step_r;                     // see R6 R14
   assign mon_sel_nxt = hit_filt ? wr_data_i[TSC_MON_MSB:TSC_MON_LSB]
                                 : mon_sel_r;                         // see R7

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fb_low_r  <= TSC_RST_FB_LOW;
         ref_div_r <= TSC_RST_REF_DIV;
         tank_r    <= TSC_RST_OSC_SET[TSC_TANK_MSB:TSC_TANK_LSB];
         cp1_r     <= TSC_RST_OSC_SET[TSC_CP1_MSB:TSC_CP1_LSB];
         cp2_r     <= TSC_RST_OSC_SET[TSC_CP2_MSB:TSC_CP2_LSB];
         step_r    <= TSC_RST_STEP;
         mon_sel_r <= TSC_RST_MON;
      end else begin
         fb_low_r  <= fb_low_nxt;
         ref_div_r <= ref_div_nxt;
         tank_r    <= tank_nxt;
         cp1_r     <= cp1_nxt;
         cp2_r     <= cp2_nxt;
         step_r    <= step_nxt;
         mon_sel_r <= mon_sel_nxt;
      end
   end

   // Registered copies driven to the analog controls, plus the write ack
   logic [9:0] cp1_ua_r;
   logic [9:0] cp2_ua_r;
   logic       step_down_r;
   logic       step_up_r;
   logic       wr_ack_r;

   wire step_down_nxt = (step_nxt == TSC_STEP_DOWN);            // see R6
   wire step_up_nxt   = (step_nxt == TSC_STEP_UP);              // see R6 R17

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cp1_ua_r    <= pump_ua(TSC_RST_OSC_SET[TSC_CP1_MSB:TSC_CP1_LSB]);
         cp2_ua_r    <= pump_ua(TSC_RST_OSC_SET[TSC_CP2_MSB:TSC_CP2_LSB]);
         step_down_r <= 1'b0;
         step_up_r   <= 1'b0;
         wr_ack_r    <= 1'b0;
      end else begin
         cp1_ua_r    <= pump_ua(cp1_nxt);                       // see R4
         cp2_ua_r    <= pump_ua(cp2_nxt);                       // see R5
         step_down_r <= step_down_nxt;
         step_up_r   <= step_up_nxt;
         wr_ack_r    <= hit_any;
      end
   end

   // Internal power-on sequence
   tsc_por_type por_state_r;
   tsc_por_type por_state_nxt;
   logic [7:0]  por_cnt_r;
   logic [7:0]  por_cnt_nxt;

   wire por_last = (por_cnt_r == TSC_POR_CYCLES - 8'h01);

   always_comb begin
      por_state_nxt = por_state_r;
      por_cnt_nxt   = por_cnt_r;
      case (por_state_r)
         TSC_POR_HOLD: begin
            por_state_nxt = TSC_POR_COUNT;
            por_cnt_nxt   = 8'h00;
         end
         TSC_POR_COUNT: begin
            por_cnt_nxt = por_cnt_r + 8'h01;
            if (por_last) begin
               por_state_nxt = TSC_POR_DONE;
            end
         end
         TSC_POR_DONE: begin
            por_state_nxt = TSC_POR_DONE;
         end
         default: begin
            por_state_nxt = TSC_POR_HOLD;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         por_state_r <= TSC_POR_HOLD;
         por_cnt_r   <= 8'h00;
      end else begin
         por_state_r <= por_state_nxt;
         por_cnt_r   <= por_cnt_nxt;
      end
   end

   // Flag registered so the pin comes straight from a flop
   logic por_done_r;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         por_done_r <= 1'b0;
      end else begin
         por_done_r <= (por_state_nxt == TSC_POR_DONE);         // see R12
      end
   end

   wire por_ok = por_done_r;

   // Status byte, reserved bits zero
   logic [7:0] status_nxt;
   logic [7:0] status_r;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic       rd_valid_r;
   logic       go_lower_r;
   logic       go_higher_r;

   always_comb begin
      status_nxt               = 8'h00;                         // see R18
      status_nxt[TSC_ST_LOOP1_LOCKED] = loop1_locked_s;                       // see R11
      status_nxt[TSC_ST_LOOP2_LOCKED] = loop2_locked_s;                       // see R11
      status_nxt[TSC_ST_POR]   = por_ok;                        // see R11 R12
      status_nxt[TSC_ST_OU1]   = ou1_s;                         // see R11
      status_nxt[TSC_ST_OU2]   = ou2_s;                         // see R11
   end

   // Tank advice follows the lock and range flags
   wire adv_lower  = !loop1_locked_s && !ou1_s;                        // see R13
   wire adv_higher = !loop1_locked_s && ou1_s;                         // see R13

   // Snapshot taken on a request, held until the next one
   assign rd_data_nxt = rd_req_i ? status_r : rd_data_r;        // see R15

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         status_r    <= 8'h00;
         rd_data_r   <= 8'h00;
         rd_valid_r  <= 1'b0;
         go_lower_r  <= 1'b0;
         go_higher_r <= 1'b0;
      end else begin
         status_r    <= status_nxt;
         rd_valid_r  <= rd_req_i;                               // see R15
         go_lower_r  <= adv_lower;
         go_higher_r <= adv_higher;
         rd_data_r   <= rd_data_nxt;
      end
   end

   // Monitor selector
   tsc_mon_if mon_if ();

   assign mon_if.sel   = mon_sel_r;
   assign mon_if.loop1_locked = loop1_locked_s;
   assign mon_if.loop2_locked = loop2_locked_s;
   assign mon_if.ou1   = ou1_s;
   assign mon_if.ou2   = ou2_s;
   assign mon_if.fb1   = fb1_s;
   assign mon_if.ref1  = ref1_s;
   assign mon_if.fb2   = fb2_s;
   assign mon_if.ref2  = ref2_s;
   assign mon_if.osc   = osc_s;

   tsc_mon_mux u_mon (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .mon_if  (mon_if)
   );

   assign wr_ack_o                = wr_ack_r;
   assign rd_data_o               = rd_data_r;
   assign rd_valid_o              = rd_valid_r;
   assign loop2_feedback_ratio_o  = fb_low_r;
   assign loop2_reference_ratio_o = ref_div_r;
   assign tank_select_o           = tank_r;
   assign loop1_pump_current_o    = cp1_r;
   assign loop2_pump_current_o    = cp2_r;
   assign loop1_pump_ua_o         = cp1_ua_r;
   assign loop2_pump_ua_o         = cp2_ua_r;
   assign filter_step_o           = step_r;
   assign filter_step_down_o      = step_down_r;
   assign filter_step_up_o        = step_up_r;
   assign monitor_o               = mon_if.mon;
   assign tank_go_lower_o         = go_lower_r;
   assign tank_go_higher_o        = go_higher_r;
   assign por_done_o              = por_done_r;

endmodule

// ===== src/tsc_pkg.sv
// Constants, field layouts and types for the tuner control register bank.
// Assumes one 25 MHz clock and a synchronous active-low reset.
// Notes on behaviour
// R1: All eight low bits feed loop-two feedback ratio
// R2: Reference ratio from bits 6..0, bit 7 ignored
// R3: Three top bits pick one of eight tanks
// R4: Bits 3..2 set loop-one pump, four steps
// R5: Bits 1..0 set loop-two pump, same steps
// R6: Filter step 00 down, 01 nominal, 11 up
// R7: Monitor code zero keeps output quiet
// R8: Codes 1,2 lock; 8,9 AND/NAND of locks
// R9: Codes 3..6 divider outputs, 7 reference oscillator
// R10: Codes 10,11 over/under of loop one, two
// R11: Status: locks 7,6, power 5, range 4,3
// R12: Power flag reads one after reset completes
// R13: Unlocked: range flag picks lower or higher tank
// R14: Filter step bits live at address eight
// R15: Host reads status byte then NACK and stop
// R16: Writes to 04h, 05h, 06h hit registers
// R17: Host avoids step 10 and monitor 1100..1111
// R18: Reserved write bits ignored, status reserved zero
package tsc_pkg;

   localparam logic [7:0] TSC_ADDR_FB_LOW   = 8'h04;
   localparam logic [7:0] TSC_ADDR_REF_DIV  = 8'h05;
   localparam logic [7:0] TSC_ADDR_OSC_SET  = 8'h06;
   localparam logic [7:0] TSC_ADDR_FILT_MON = 8'h08;

   localparam logic [7:0] TSC_RST_FB_LOW   = 8'h00;
   localparam logic [6:0] TSC_RST_REF_DIV  = 7'h00;
   localparam logic [7:0] TSC_RST_OSC_SET  = 8'h00;
   localparam logic [1:0] TSC_RST_STEP     = 2'h1;
   localparam logic [3:0] TSC_RST_MON      = 4'h0;

   localparam int TSC_TANK_MSB  = 7;
   localparam int TSC_TANK_LSB  = 5;
   localparam int TSC_CP1_MSB   = 3;
   localparam int TSC_CP1_LSB   = 2;
   localparam int TSC_CP2_MSB   = 1;
   localparam int TSC_CP2_LSB   = 0;
   localparam int TSC_STEP_MSB  = 5;
   localparam int TSC_STEP_LSB  = 4;
   localparam int TSC_MON_MSB   = 3;
   localparam int TSC_MON_LSB   = 0;
   localparam int TSC_REF_MSB   = 6;

   localparam int TSC_ST_LOOP1_LOCKED  = 7;
   localparam int TSC_ST_LOOP2_LOCKED  = 6;
   localparam int TSC_ST_POR    = 5;
   localparam int TSC_ST_OU1    = 4;
   localparam int TSC_ST_OU2    = 3;

   localparam logic [1:0] TSC_STEP_DOWN = 2'h0;
   localparam logic [1:0] TSC_STEP_NOM  = 2'h1;
   localparam logic [1:0] TSC_STEP_UP   = 2'h3;

   localparam logic [9:0] TSC_PUMP_STEP_UA = 10'h0C8;

   // Internal power-on settling, cycles after reset release
   localparam logic [7:0] TSC_POR_CYCLES = 8'h10;

   typedef enum logic [3:0] {
      TSC_MON_QUIET,
      TSC_MON_LOOP1_LOCKED,
      TSC_MON_LOOP2_LOCKED,
      TSC_MON_FB1,
      TSC_MON_REF1,
      TSC_MON_FB2,
      TSC_MON_REF2,
      TSC_MON_OSC,
      TSC_MON_AND,
      TSC_MON_NAND,
      TSC_MON_OU1,
      TSC_MON_OU2
   } tsc_mon_type;

   typedef enum logic [1:0] {
      TSC_POR_HOLD,
      TSC_POR_COUNT,
      TSC_POR_DONE
   } tsc_por_type;

endpackage

// ===== src/tsc_mon_if.sv
// Carries monitor select, synchronised sources and the monitor level.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface tsc_mon_if;
   logic [3:0] sel;
   logic       loop1_locked;
   logic       loop2_locked;
   logic       fb1;
   logic       ref1;
   logic       fb2;
   logic       ref2;
   logic       osc;
   logic       ou1;
   logic       ou2;
   logic       mon;

   modport ctrl (output sel, loop1_locked, loop2_locked, fb1, ref1, fb2, ref2, osc,
                 ou1, ou2, input mon);
   modport mux  (input sel, loop1_locked, loop2_locked, fb1, ref1, fb2, ref2, osc,
                 ou1, ou2, output mon);
endinterface

// ===== src/tsc_mon_mux.sv
// Monitor output selector driven by the filter/monitor register.
// Assumes sources already synchronised to mclk_i.
`timescale 1ns/1ns
module tsc_mon_mux
   import tsc_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   tsc_mon_if.mux    mon_if
);

   logic mon_nxt;
   logic mon_r;

   always_comb begin
      case (mon_if.sel)
         TSC_MON_QUIET: mon_nxt = 1'b0;                 // see R7
         TSC_MON_LOOP1_LOCKED: mon_nxt = mon_if.loop1_locked;         // see R8
         TSC_MON_LOOP2_LOCKED: mon_nxt = mon_if.loop2_locked;         // see R8
         TSC_MON_FB1:   mon_nxt = mon_if.fb1;           // see R9
         TSC_MON_REF1:  mon_nxt = mon_if.ref1;          // see R9
         TSC_MON_FB2:   mon_nxt = mon_if.fb2;           // see R9
         TSC_MON_REF2:  mon_nxt = mon_if.ref2;          // see R9
         TSC_MON_OSC:   mon_nxt = mon_if.osc;           // see R9
         TSC_MON_AND:   mon_nxt = mon_if.loop1_locked & mon_if.loop2_locked;    // see R8
         TSC_MON_NAND:  mon_nxt = ~(mon_if.loop1_locked & mon_if.loop2_locked); // see R8
         TSC_MON_OU1:   mon_nxt = mon_if.ou1;           // see R10
         TSC_MON_OU2:   mon_nxt = mon_if.ou2;           // see R10
         default:       mon_nxt = 1'b0;                 // see R17
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mon_r <= 1'b0;
      end else begin
         mon_r <= mon_nxt;
      end
   end

   assign mon_if.mon = mon_r;

endmodule

// ===== tb/tsc_regs_chk.sv
// Port-level assertions for the tuner control register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module tsc_regs_chk
   import tsc_pkg::*;
(
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       wr_en_i,
   input wire logic [7:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic       rd_req_i,
   input wire logic       wr_ack_o,
   input wire logic [7:0] rd_data_o,
   input wire logic       rd_valid_o,
   input wire logic [7:0] loop2_feedback_ratio_o,
   input wire logic [6:0] loop2_reference_ratio_o,
   input wire logic [2:0] tank_select_o,
   input wire logic [1:0] loop1_pump_current_o,
   input wire logic [1:0] loop2_pump_current_o,
   input wire logic [9:0] loop1_pump_ua_o,
   input wire logic [9:0] loop2_pump_ua_o,
   input wire logic [1:0] filter_step_o,
   input wire logic       filter_step_down_o,
   input wire logic       filter_step_up_o,
   input wire logic       monitor_o,
   input wire logic       por_done_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] data_r;
   wire logic  map_w = wr_en_i && wr_addr_i inside {TSC_ADDR_FB_LOW,
                       TSC_ADDR_REF_DIV, TSC_ADDR_OSC_SET, TSC_ADDR_FILT_MON};
   wire logic  mon_w = wr_en_i && wr_addr_i == TSC_ADDR_FILT_MON;
   always_ff @(posedge mclk_i) data_r <= wr_data_i;

   a_ack_mapped: assert property (map_w |=> wr_ack_o)
      else $error("mapped write not acknowledged");
   a_no_ack_unmap: assert property (wr_en_i && !map_w |=> !wr_ack_o)
      else $error("unmapped write acknowledged");
   a_fb_low_load: assert property (
      wr_en_i && wr_addr_i == TSC_ADDR_FB_LOW
      |=> loop2_feedback_ratio_o == data_r)
      else $error("feedback low ratio wrong");
   a_ref_ratio_load: assert property (
      wr_en_i && wr_addr_i == TSC_ADDR_REF_DIV
      |=> loop2_reference_ratio_o == data_r[6:0])
      else $error("reference ratio wrong");
   a_osc_set_load: assert property (
      wr_en_i && wr_addr_i == TSC_ADDR_OSC_SET
      |=> {tank_select_o, loop1_pump_current_o, loop2_pump_current_o}
          == {data_r[7:5], data_r[3:0]})
      else $error("tank or pump fields wrong");
   a_step_load: assert property (
      mon_w |=> filter_step_o == data_r[5:4])
      else $error("filter step field wrong");
   a_pump_steps: assert property (
      loop1_pump_ua_o == TSC_PUMP_STEP_UA * (loop1_pump_current_o + 10'h1) &&
      loop2_pump_ua_o == TSC_PUMP_STEP_UA * (loop2_pump_current_o + 10'h1))
      else $error("pump current steps wrong");
   a_step_decode: assert property (
      filter_step_down_o == (filter_step_o == TSC_STEP_DOWN) &&
      filter_step_up_o == (filter_step_o == TSC_STEP_UP))
      else $error("filter step decode wrong");
   a_status_rsvd: assert property (
      rd_valid_o |-> rd_data_o[2:0] == 3'h0)
      else $error("reserved status bits not zero");
   a_read_answer: assert property (rd_req_i |=> rd_valid_o)
      else $error("status read not answered");
   a_mon_quiet: assert property (
      mon_w && wr_data_i[3:0] == 4'h0 ##1 !mon_w |=> !monitor_o)
      else $error("monitor not quiet on code zero");
   a_por_delay: assert property (
      $rose(rst_n_i) |-> !por_done_o ##[15:19] por_done_o)
      else $error("power-on flag timing wrong");
   a_por_holds: assert property (por_done_o |=> por_done_o)
      else $error("power-on flag dropped");

   c_osc_write: cover property (wr_en_i && wr_addr_i == TSC_ADDR_OSC_SET);
   c_locked_read: cover property (rd_valid_o && rd_data_o[7]);
   c_mon_active: cover property (monitor_o);
   c_step_up: cover property (filter_step_up_o);
endmodule

bind tsc_regs tsc_regs_chk u_chk (.*);

// ===== tb/tsc_host.sv
// Host partner model issuing byte writes and status reads.
// Assumes serial framing is already decoded into these strobes.
`timescale 1ns/1ns
module tsc_host
   import tsc_pkg::*;
(
   input  wire logic       mclk_i,
   output logic            wr_en_o,
   output logic [7:0]      wr_addr_o,
   output logic [7:0]      wr_data_o,
   output logic            rd_req_o
);
   initial begin
      wr_en_o = 1'b0;
      wr_addr_o = 8'h00;
      wr_data_o = 8'h00;
      rd_req_o = 1'b0;
   end

   // Strobe stays up, so calls run back to back
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == TSC_ADDR_FILT_MON && v[5:4] == 2'h2)
         v[5:4] = 2'h1;
      if (a == TSC_ADDR_FILT_MON && v[3:0] > 4'hB)
         v[3:0] = 4'h0;
      @(posedge mclk_i);
      #2;
      wr_en_o = 1'b1;
      wr_addr_o = a;
      wr_data_o = v;
   endtask

   // Released lines show inverted data
   task automatic idle;
      @(posedge mclk_i);
      #2;
      wr_en_o = 1'b0;
      wr_addr_o = ~wr_addr_o;
      wr_data_o = ~wr_data_o;
   endtask

   // One status byte per request, then the request ends
   task automatic read;
      @(posedge mclk_i);
      #2;
      rd_req_o = 1'b1;
      @(posedge mclk_i);
      #2;
      rd_req_o = 1'b0;
   endtask
endmodule

// ===== tb/tsc_regs_tb.sv
// Self-checking bench for the tuner control register bank.
// Assumes tsc_host as host partner and the bound port checker.
`timescale 1ns/1ns
module tsc_regs_tb
   import tsc_pkg::*;
;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   wire logic   wr_en_i, rd_req_i;
   wire logic   [7:0] wr_addr_i, wr_data_i;
   wire logic   loop1_locked_i, loop2_locked_i, loop1_tune_out_of_range_i;
   wire logic   loop2_tune_out_of_range_i, loop1_fb_div_i, loop1_ref_div_i;
   wire logic   loop2_fb_div_i, loop2_ref_div_i, ref_osc_i;
   logic        wr_ack_o, rd_valid_o, monitor_o, por_done_o;
   logic        tank_go_lower_o, tank_go_higher_o;
   logic        filter_step_down_o, filter_step_up_o;
   logic [7:0]  rd_data_o, loop2_feedback_ratio_o, wa, wd;
   logic [6:0]  loop2_reference_ratio_o;
   logic [2:0]  tank_select_o;
   logic [1:0]  loop1_pump_current_o, loop2_pump_current_o, filter_step_o;
   logic [1:0]  adv;
   logic [9:0]  loop1_pump_ua_o, loop2_pump_ua_o;
   logic [24:0] exp_q[$];
   logic [24:0] nt;
   logic [23:0] shd;
   logic [8:0]  pv = 9'h000;
   logic        mv;
   logic [7:0]  amap [8] = '{8'h04, 8'h05, 8'h06, 8'h08,
                              8'h00, 8'h07, 8'h09, 8'hFF};
   logic [1:0]  stp [3] = '{2'h0, 2'h1, 2'h3};
   int          bad_count = 0;
   int          n_checks = 0;
   wire logic [23:0] regs_w = {loop2_feedback_ratio_o, loop2_reference_ratio_o,
      tank_select_o, loop1_pump_current_o, loop2_pump_current_o, filter_step_o};

   assign {loop1_locked_i, loop2_locked_i, loop1_tune_out_of_range_i,
           loop2_tune_out_of_range_i, loop1_fb_div_i, loop1_ref_div_i,
           loop2_fb_div_i, loop2_ref_div_i, ref_osc_i} = pv;

   tsc_regs dut (.*);
   tsc_host u_host (.mclk_i(mclk_i), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
                    .wr_data_o(wr_data_i), .rd_req_o(rd_req_i));

   always #20 mclk_i = ~mclk_i;

   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic mon_exp(input logic [3:0] c, input logic [8:0] p);
      logic [11:0] t;
      t = {p[5], p[6], ~(p[8] & p[7]), p[8] & p[7], p[0], p[1], p[2], p[3],
           p[4], p[7], p[8], 1'b0};
      return t[c];
   endfunction

   task automatic set_pins(input logic [8:0] v);
      @(posedge mclk_i);
      #2 pv = v;
   endtask

   // Shadow the register image and note the expected ack
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      case (a)
         TSC_ADDR_FB_LOW:   shd[23:16] = d;
         TSC_ADDR_REF_DIV:  shd[15:9] = d[6:0];
         TSC_ADDR_OSC_SET:  shd[8:2] = {d[7:5], d[3:0]};
         TSC_ADDR_FILT_MON: shd[1:0] = d[5:4];
         default: ;
      endcase
      if (a inside {TSC_ADDR_FB_LOW, TSC_ADDR_REF_DIV, TSC_ADDR_OSC_SET,
                    TSC_ADDR_FILT_MON})
         exp_q.push_back({1'b0, shd});
      u_host.write(a, d);
   endtask

   task automatic do_reset;
      @(posedge mclk_i);
      #2 rst_n_i = 1'b0;
      repeat (3) @(posedge mclk_i);
      #2 rst_n_i = 1'b1;
      exp_q.delete();
      shd = {8'h00, 7'h00, 3'h0, 2'h0, 2'h0, TSC_STEP_NOM};
      chk({1'b0, regs_w}, {1'b0, shd});
      chk({24'h0, por_done_o}, 25'h0);
   endtask

   always @(posedge mclk_i) begin
      #1;
      if (rst_n_i === 1'b1 && (wr_ack_o === 1'b1 || rd_valid_o === 1'b1)) begin
         nt = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1FFFFFF;
         if (wr_ack_o === 1'b1)
            chk({1'b0, regs_w}, nt);
         else
            chk({9'h100, 8'h00, rd_data_o}, nt);
      end
   end

   initial begin
      void'($urandom(23));
      do_reset;
      repeat (20) @(posedge mclk_i);
      for (int i = 0; i < 16; i++) begin
         set_pins({i[3:0], 5'($urandom)});
         repeat (4) @(posedge mclk_i);
         exp_q.push_back({17'h10000, i[3:2], 1'b1, i[1:0], 3'h0});
         u_host.read;
         adv = {~i[3] & ~i[1], ~i[3] & i[1]};
         chk({23'h0, tank_go_lower_o, tank_go_higher_o}, {23'h0, adv});
      end
      for (int t = 0; t < 8; t++)
         wr(TSC_ADDR_OSC_SET, {t[2:0], 1'b1, t[1:0], ~t[1:0]});
      foreach (stp[j])
         wr(TSC_ADDR_FILT_MON, {2'h3, stp[j], 4'h0});
      wr(TSC_ADDR_REF_DIV, 8'hFF);
      for (int k = 0; k < 40; k++) begin
         wa = amap[$urandom % 8];
         wd = 8'($urandom);
         if (wa == TSC_ADDR_FILT_MON)
            wd[5:0] = {stp[$urandom % 3], 4'($urandom % 12)};
         wr(wa, wd);
      end
      u_host.idle;
      for (int c = 0; c < 12; c++) begin
         set_pins(9'($urandom));
         wr(TSC_ADDR_FILT_MON, {4'h1, c[3:0]});
         u_host.idle;
         repeat (4) @(posedge mclk_i);
         #1;
         mv = mon_exp(c[3:0], pv);
         chk({24'h0, monitor_o}, {24'h0, mv});
      end
      set_pins(9'h1A0);
      do_reset;
      repeat (20) @(posedge mclk_i);
      exp_q.push_back({17'h10000, 2'h3, 1'b1, 2'h1, 3'h0});
      u_host.read;
      repeat (3) @(posedge mclk_i);
      chk(25'(exp_q.size()), 25'h0);
      give_verdict;
   end

   initial begin
      #100000;
      bad_count++;
      give_verdict;
   end
endmodule
